// [pkg/sptg_defines.svh]
/*
 * Constants of the scaled pulse train generator: register offsets,
 * field positions, reset values, selector codes and timing counts.
 * Assumes a 125 MHz system clock and byte addresses on the bus.
 */
`ifndef SPTG_DEFINES_SVH
`define SPTG_DEFINES_SVH

// Register byte offsets
`define SPTG_OFS_CTRL 6'h00
`define SPTG_OFS_NUM 6'h04
`define SPTG_OFS_DEN 6'h08
`define SPTG_OFS_FMIN 6'h0C
`define SPTG_OFS_FMAX 6'h10
`define SPTG_OFS_INMIN 6'h14
`define SPTG_OFS_INMAX 6'h18
`define SPTG_OFS_ROUTE 6'h1C
`define SPTG_OFS_STATUS 6'h20
`define SPTG_OFS_PERIOD 6'h24

// Control field positions
`define SPTG_CTRL_SEL_MSB 5
`define SPTG_CTRL_CORR_BIT 8

// Reset values
`define SPTG_RST_SEL 6'h00
`define SPTG_RST_NUM 14'h0001
`define SPTG_RST_DEN 14'h0002
`define SPTG_RST_FMIN 7'h00
`define SPTG_RST_FMAX 7'h32
`define SPTG_RST_INMIN 16'h0000
`define SPTG_RST_INMAX 16'h0064
`define SPTG_RST_ROUTE 4'h0

// Selector codes
`define SPTG_SEL_OFF 6'h00
`define SPTG_SEL_REV 6'h01
`define SPTG_SEL_CONST 6'h02
`define SPTG_SEL_PV_FIRST 6'h03
`define SPTG_SEL_PV_LAST 6'h38

// Timing
`define SPTG_CLK_MHZ 125
`define SPTG_QUANT_US 1500
`define SPTG_QUANT_CYC (`SPTG_QUANT_US * `SPTG_CLK_MHZ)
`define SPTG_MIN_LEN_US 32'd3000
`define SPTG_FIX_PCT 48'd20
`define SPTG_MAX_PCT 48'd90
`define SPTG_PCT_FULL 32'd100
`define SPTG_US_PER_S 48'd1000000
`define SPTG_MHZ_PER_HZ 48'd1000
`define SPTG_REV_SHIFT 16

`endif

// [pkg/sptg_pkg.sv]
/*
 * Types shared by the pulse train generator files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sptg_pkg;

	// Background calculation steps
	typedef enum logic [1:0] {SPTG_ST_FREQ, SPTG_ST_PER, SPTG_ST_CAP, SPTG_ST_LEN} sptg_calc_e;

	typedef logic [31:0] sptg_word_t;

endpackage : sptg_pkg

// [core/sptg_divider.sv]
/*
 * Sequential restoring divider, 48-bit dividend by 32-bit divisor.
 * Assumes start is only pulsed while idle; a zero divisor gives all ones.
 */
`timescale 1ns/1ps

module sptg_divider (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [47:0] dividend_in,
	input wire logic [31:0] divisor_in,
	output logic done_out,
	output logic [47:0] quotient_out
);

	logic [31:0] rem_ff;
	logic [31:0] div_ff;
	logic [5:0] cnt_ff;
	logic busy_ff;
	logic [32:0] shifted;
	logic fits;

	assign shifted = {rem_ff, quotient_out[47]};
	assign fits = shifted >= {1'b0, div_ff};

	// One quotient bit per clock, 48 clocks per division
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rem_ff <= 32'h0000_0000;
			div_ff <= 32'h0000_0000;
			cnt_ff <= 6'h00;
			busy_ff <= 1'b0;
			done_out <= 1'b0;
			quotient_out <= 48'h0000_0000_0000;
		end
		else if (ce_in)
		begin
			done_out <= 1'b0;
			if (start_in && !busy_ff)
			begin
				rem_ff <= 32'h0000_0000;
				div_ff <= divisor_in;
				quotient_out <= dividend_in;
				cnt_ff <= 6'h30;
				busy_ff <= 1'b1;
			end
			else if (busy_ff)
			begin
				rem_ff <= fits ? 32'(shifted - {1'b0, div_ff}) : shifted[31:0];
				quotient_out <= {quotient_out[46:0], fits};
				cnt_ff <= cnt_ff - 6'h01;
				if (cnt_ff == 6'h01)
				begin
					busy_ff <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end

endmodule : sptg_divider

// [core/sptg_top.sv]
/*
 * Scaled pulse train generator with an Avalon-MM register slave.
 * Assumes synchronous inputs, a 16-bit shaft angle per revolution and a
 * process value chosen outside from value_select_out.
 */
// Operation
// - Pulse train follows ratio, angle or value
// - Selector zero keeps output idle
// - Mode 1: ratio pulses per shaft revolution
// - Mode 2: frequency equals ratio in hertz
// - Modes 1,2: pulse 20 percent, min 3 ms
// - Modes 3..56: frequency scales with value
// - Value modes: pulse is period times ratio
// - Default ratio one half gives 50 percent
// - Value modes: pulse within 3 ms..90 percent
// - Output feeds internal blocks and four outputs
// - Ratio factors enter count, frequency, length
// - Input range maps linearly onto frequency range
// - 1.5 ms quantum, optional error carry
`timescale 1ns/1ps
`include "sptg_defines.svh"

module sptg_top #(
	parameter int QUANT_CYCLES = `SPTG_QUANT_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic encoder_present_in,
	input wire logic [15:0] encoder_angle_in,
	input wire logic [15:0] encoder_emulation_in,
	input wire logic [15:0] process_value_in,
	output logic [5:0] value_select_out,
	output logic pulse_train_out,
	output logic open_collector_out_1,
	output logic open_collector_out_2,
	output logic open_collector_out_3,
	output logic open_collector_out_4
);

	////////////////////////////////////////////////////////////////////
	// Register slave
	logic [5:0] sel_ff;
	logic corr_ff;
	logic [13:0] num_ff;
	logic [13:0] den_ff;
	logic [6:0] fmin_ff;
	logic [6:0] fmax_ff;
	logic [15:0] in_min_ff;
	logic [15:0] in_max_ff;
	logic [3:0] route_ff;
	sptg_pkg::sptg_word_t per_us_ff;
	sptg_pkg::sptg_word_t nxt_rdata;
	logic req;
	logic wr_en;
	logic active;

	assign req = avs_read_in | avs_write_in;
	assign wr_en = ce_in && avs_write_in && !avs_waitrequest_out;

	// One wait state, then the access completes; idle reads as waiting
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0000_0000;
		end
		else if (ce_in)
		begin
			avs_waitrequest_out <= !(req && avs_waitrequest_out);
			if (req && avs_waitrequest_out)
				avs_readdata_out <= nxt_rdata;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		case (avs_address_in)
			`SPTG_OFS_CTRL: nxt_rdata = {23'h0, corr_ff, 2'h0, sel_ff};
			`SPTG_OFS_NUM: nxt_rdata = {18'h0, num_ff};
			`SPTG_OFS_DEN: nxt_rdata = {18'h0, den_ff};
			`SPTG_OFS_FMIN: nxt_rdata = {25'h0, fmin_ff};
			`SPTG_OFS_FMAX: nxt_rdata = {25'h0, fmax_ff};
			`SPTG_OFS_INMIN: nxt_rdata = {16'h0, in_min_ff};
			`SPTG_OFS_INMAX: nxt_rdata = {16'h0, in_max_ff};
			`SPTG_OFS_ROUTE: nxt_rdata = {28'h0, route_ff};
			`SPTG_OFS_STATUS: nxt_rdata = {30'h0, active, pulse_train_out};
			`SPTG_OFS_PERIOD: nxt_rdata = per_us_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Writable settings; a zero ratio factor is raised to one
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sel_ff <= `SPTG_RST_SEL;
			corr_ff <= 1'b0;
			num_ff <= `SPTG_RST_NUM;
			den_ff <= `SPTG_RST_DEN;
			fmin_ff <= `SPTG_RST_FMIN;
			fmax_ff <= `SPTG_RST_FMAX;
			in_min_ff <= `SPTG_RST_INMIN;
			in_max_ff <= `SPTG_RST_INMAX;
			route_ff <= `SPTG_RST_ROUTE;
		end
		else if (wr_en)
		begin
			case (avs_address_in)
				`SPTG_OFS_CTRL:
				begin
					sel_ff <= avs_writedata_in[`SPTG_CTRL_SEL_MSB:0];
					corr_ff <= avs_writedata_in[`SPTG_CTRL_CORR_BIT];
				end
				`SPTG_OFS_NUM: num_ff <= (avs_writedata_in[13:0] == 14'h0) ? 14'h0001 :
					avs_writedata_in[13:0];
				`SPTG_OFS_DEN: den_ff <= (avs_writedata_in[13:0] == 14'h0) ? 14'h0001 :
					avs_writedata_in[13:0];
				`SPTG_OFS_FMIN: fmin_ff <= avs_writedata_in[6:0];
				`SPTG_OFS_FMAX: fmax_ff <= avs_writedata_in[6:0];
				`SPTG_OFS_INMIN: in_min_ff <= avs_writedata_in[15:0];
				`SPTG_OFS_INMAX: in_max_ff <= avs_writedata_in[15:0];
				`SPTG_OFS_ROUTE: route_ff <= avs_writedata_in[3:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Mode decode
	logic is_rev;
	logic is_const;
	logic is_pv;
	logic [47:0] f_mhz_ff;

	assign is_rev = sel_ff == `SPTG_SEL_REV;
	assign is_const = sel_ff == `SPTG_SEL_CONST;
	assign is_pv = sel_ff >= `SPTG_SEL_PV_FIRST && sel_ff <= `SPTG_SEL_PV_LAST;
	assign active = is_rev || is_const || (is_pv && f_mhz_ff != 48'h0);

	////////////////////////////////////////////////////////////////////
	// Background calculation, one shared divider
	sptg_pkg::sptg_calc_e st_ff;
	logic issued_ff;
	logic div_done;
	logic [47:0] div_q;
	logic [47:0] dividend;
	logic [31:0] divisor;
	logic [31:0] per_ang_ff;
	logic [31:0] cap_ff;
	logic [31:0] len_ff;
	logic [31:0] meas_ff;
	logic [31:0] q_sat;
	logic [16:0] pv_diff;
	logic [16:0] in_span;
	logic pv_low;
	logic pv_high;

	assign pv_low = $signed(process_value_in) <= $signed(in_min_ff);
	assign pv_high = $signed(process_value_in) >= $signed(in_max_ff);
	assign pv_diff = 17'($signed(process_value_in) - $signed(in_min_ff));
	assign in_span = 17'($signed(in_max_ff) - $signed(in_min_ff));
	assign q_sat = (div_q[47:32] != 16'h0) ? 32'hFFFF_FFFF : div_q[31:0];

	// Operands per step
	always_comb
	begin
		dividend = 48'h0;
		divisor = 32'h1;
		case (st_ff)
			sptg_pkg::SPTG_ST_FREQ:
			begin
				dividend = 48'(pv_diff) * 48'(fmax_ff - fmin_ff) * `SPTG_MHZ_PER_HZ;
				divisor = 32'(in_span);
			end
			sptg_pkg::SPTG_ST_PER:
			begin
				if (is_rev)
				begin
					dividend = 48'(den_ff) << `SPTG_REV_SHIFT;
					divisor = 32'(num_ff);
				end
				else if (is_const)
				begin
					dividend = `SPTG_US_PER_S * 48'(den_ff);
					divisor = 32'(num_ff);
				end
				else
				begin
					dividend = `SPTG_US_PER_S * `SPTG_MHZ_PER_HZ;
					divisor = f_mhz_ff[31:0];
				end
			end
			sptg_pkg::SPTG_ST_CAP:
			begin
				dividend = 48'(per_us_ff) * `SPTG_MAX_PCT;
				divisor = `SPTG_PCT_FULL;
			end
			sptg_pkg::SPTG_ST_LEN:
			begin
				if (is_pv)
				begin
					dividend = 48'(per_us_ff) * 48'(num_ff);
					divisor = 32'(den_ff);
				end
				else
				begin
					dividend = 48'(is_rev ? meas_ff : per_us_ff) * `SPTG_FIX_PCT;
					divisor = `SPTG_PCT_FULL;
				end
			end
			default: ;
		endcase
	end

	sptg_divider u_div (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.start_in(!issued_ff),
		.dividend_in(dividend),
		.divisor_in(divisor),
		.done_out(div_done),
		.quotient_out(div_q)
	);

	// Step sequencing and result storage
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st_ff <= sptg_pkg::SPTG_ST_FREQ;
			issued_ff <= 1'b0;
			f_mhz_ff <= 48'h0;
			per_us_ff <= 32'hFFFF_FFFF;
			per_ang_ff <= 32'hFFFF_FFFF;
			cap_ff <= `SPTG_MIN_LEN_US;
			len_ff <= `SPTG_MIN_LEN_US;
		end
		else if (ce_in)
		begin
			if (!issued_ff)
				issued_ff <= 1'b1;
			else if (div_done)
			begin
				issued_ff <= 1'b0;
				case (st_ff)
					sptg_pkg::SPTG_ST_FREQ:
					begin
						if (fmax_ff < fmin_ff || pv_low || in_span[16])
							f_mhz_ff <= 48'(fmin_ff) * `SPTG_MHZ_PER_HZ;
						else if (pv_high)
							f_mhz_ff <= 48'(fmax_ff) * `SPTG_MHZ_PER_HZ;
						else
							f_mhz_ff <= 48'(fmin_ff) * `SPTG_MHZ_PER_HZ + div_q;
						st_ff <= sptg_pkg::SPTG_ST_PER;
					end
					sptg_pkg::SPTG_ST_PER:
					begin
						if (is_rev)
							per_ang_ff <= q_sat;
						else
							per_us_ff <= q_sat;
						st_ff <= sptg_pkg::SPTG_ST_CAP;
					end
					sptg_pkg::SPTG_ST_CAP:
					begin
						cap_ff <= q_sat;
						st_ff <= sptg_pkg::SPTG_ST_LEN;
					end
					sptg_pkg::SPTG_ST_LEN:
					begin
						if (is_pv && q_sat > cap_ff)
							len_ff <= (cap_ff < `SPTG_MIN_LEN_US) ? `SPTG_MIN_LEN_US : cap_ff;
						else
							len_ff <= (q_sat < `SPTG_MIN_LEN_US) ? `SPTG_MIN_LEN_US : q_sat;
						st_ff <= sptg_pkg::SPTG_ST_FREQ;
					end
					default: st_ff <= sptg_pkg::SPTG_ST_FREQ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pulse engine, stepped on the 1.5 ms quantum
	logic [17:0] qcnt_ff;
	logic tick_ff;
	logic first_ff;
	logic [31:0] elapsed_ff;
	logic [31:0] cur_per_ff;
	logic [31:0] cur_len_ff;
	logic [31:0] ang_acc_ff;
	logic [15:0] last_ang_ff;
	logic [15:0] angle;
	logic [15:0] ang_delta;
	logic [32:0] sum_us;
	logic [32:0] ang_sum;
	logic start;
	logic nxt_pulse;

	assign angle = encoder_present_in ? encoder_angle_in : encoder_emulation_in;
	assign ang_delta = angle - last_ang_ff;
	assign sum_us = {1'b0, elapsed_ff} + 33'(`SPTG_QUANT_US);
	assign ang_sum = {1'b0, ang_acc_ff} + 33'(ang_delta[15] ? 16'(-ang_delta) : ang_delta);
	// Period start by angle or time
	// Live period: a stale value latched at activation could hold the output for hours
	assign start = tick_ff && active && (first_ff ||
		(is_rev ? ang_sum >= {1'b0, per_ang_ff} : sum_us >= {1'b0, per_us_ff}));
	// High from start for the length
	assign nxt_pulse = active && (start || (sum_us < {1'b0, cur_len_ff}));

	// Quantum tick; the count is a parameter so simulation can shorten it
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			qcnt_ff <= 18'h0;
			tick_ff <= 1'b0;
		end
		else if (ce_in)
		begin
			tick_ff <= qcnt_ff == 18'(QUANT_CYCLES - 1);
			qcnt_ff <= (qcnt_ff == 18'(QUANT_CYCLES - 1)) ? 18'h0 : qcnt_ff + 18'h1;
		end
	end

	// Time and angle accumulators
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			first_ff <= 1'b1;
			elapsed_ff <= 32'h0;
			ang_acc_ff <= 32'h0;
			last_ang_ff <= 16'h0;
			cur_per_ff <= 32'hFFFF_FFFF;
			cur_len_ff <= `SPTG_MIN_LEN_US;
			meas_ff <= 32'hFFFF_FFFF;
		end
		else if (ce_in)
		begin
			if (!active)
			begin
				first_ff <= 1'b1;
				elapsed_ff <= 32'h0;
				ang_acc_ff <= 32'h0;
			end
			else if (tick_ff)
			begin
				last_ang_ff <= angle;
				ang_acc_ff <= ang_sum[32] ? 32'hFFFF_FFFF : ang_sum[31:0];
				elapsed_ff <= sum_us[32] ? 32'hFFFF_FFFF : sum_us[31:0];
				if (start)
				begin
					first_ff <= 1'b0;
					cur_per_ff <= per_us_ff;
					cur_len_ff <= len_ff;
					if (corr_ff && !first_ff && !is_rev)
						elapsed_ff <= 32'(sum_us - {1'b0, per_us_ff});
					else
						elapsed_ff <= 32'h0;
					if (is_rev)
					begin
						meas_ff <= sum_us[32] ? 32'hFFFF_FFFF : sum_us[31:0];
						ang_acc_ff <= (corr_ff && !first_ff) ?
							32'(ang_sum - {1'b0, per_ang_ff}) : 32'h0;
					end
				end
			end
		end
	end

	// Output stage, internal and open-collector copies
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pulse_train_out <= 1'b0;
			value_select_out <= 6'h00;
			{open_collector_out_4, open_collector_out_3,
				open_collector_out_2, open_collector_out_1} <= 4'h0;
		end
		else if (ce_in)
		begin
			value_select_out <= sel_ff;
			// Output moves on the quantum, or drops low on the next clock while inactive
			if (tick_ff || !active)
			begin
				pulse_train_out <= nxt_pulse;
				{open_collector_out_4, open_collector_out_3,
					open_collector_out_2, open_collector_out_1} <= route_ff & {4{nxt_pulse}};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_bus_take;
		ce_in && req && avs_waitrequest_out;
	endsequence

	a_idle_no_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && sel_ff == `SPTG_SEL_OFF) |=> !pulse_train_out)
		else $error("pulse seen while selector is zero");
	a_route_follows: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && (tick_ff || !active)) |=> {open_collector_out_4, open_collector_out_3,
		open_collector_out_2, open_collector_out_1} == ($past(route_ff) & {4{pulse_train_out}}))
		else $error("open collector outputs disagree with pulse");
	a_len_floor: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && start) |=> cur_len_ff >= `SPTG_MIN_LEN_US)
		else $error("pulse length under 3 ms");
	a_len_cap: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && div_done && issued_ff && is_pv && st_ff == sptg_pkg::SPTG_ST_LEN)
		|=> (len_ff == `SPTG_MIN_LEN_US || len_ff <= $past(cap_ff)))
		else $error("pulse length above 90 percent");
	a_bus_answer: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_bus_take |=> !avs_waitrequest_out ##1 avs_waitrequest_out || !ce_in)
		else $error("bus answer not one cycle wide");
	a_num_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(s_bus_take ##1 (ce_in && avs_write_in && avs_address_in == `SPTG_OFS_NUM
		&& avs_writedata_in[13:0] != 14'h0)) |=> num_ff == $past(avs_writedata_in[13:0]))
		else $error("numerator write lost");
	a_no_carry: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && start && !corr_ff) |=> elapsed_ff == 32'h0)
		else $error("elapsed time kept without correction");
	a_start_high: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ce_in && start) |=> pulse_train_out && cur_per_ff == $past(per_us_ff))
		else $error("period start without high output");

endmodule : sptg_top

// [sim/sptg_pulse_rx.sv]
/*
 * Pulse receiver standing in for a controller input on one output line.
 * Assumes a clean level synchronous to clk_in.
 */
`timescale 1ns/1ps

module sptg_pulse_rx (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic line_in,
	output logic [31:0] rise_count_out,
	output logic [31:0] period_out,
	output logic [31:0] high_out
);
	logic line_ff;
	logic [31:0] since_rise_ff;
	logic [31:0] high_run_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Rising edges and cycles between them; a receiver sees only edges
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			line_ff <= 1'b0;
			since_rise_ff <= 32'h0;
			rise_count_out <= 32'h0;
			period_out <= 32'h0;
		end
		else
		begin
			line_ff <= line_in;
			since_rise_ff <= (line_in && !line_ff) ? 32'h1 : since_rise_ff + 32'h1;
			if (line_in && !line_ff)
			begin
				rise_count_out <= rise_count_out + 32'h1;
				period_out <= since_rise_ff;
			end
		end
	end

	// Width of the last high phase, taken at the falling edge
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			high_run_ff <= 32'h0;
			high_out <= 32'h0;
		end
		else
		begin
			high_run_ff <= line_in ? high_run_ff + 32'h1 : 32'h0;
			if (!line_in && line_ff)
				high_out <= high_run_ff;
		end
	end
endmodule : sptg_pulse_rx

// [sim/sptg_top_bench.sv]
/*
 * Self-checking bench: bus tasks, integer model of period and length.
 * Assumes a short quantum so that all times scale down together.
 */
`timescale 1ns/1ps
`include "sptg_defines.svh"

module sptg_top_bench;
	localparam int Q = 20;
	localparam int LIMIT = 90000;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [5:0] adr = 6'h00;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wait_req;
	logic enc_present = 1'b1;
	logic ce = 1'b1;
	logic [15:0] angle = 16'h0;
	logic [15:0] emul = 16'h0;
	logic [15:0] pv_tab [0:63];
	logic [5:0] vsel;
	logic pulse, oc1, oc2, oc3, oc4, prev_pulse;
	logic [31:0] rx_rises, rx_period, rx_high, rd;
	logic [3:0] route_m = 4'h0;
	logic [31:0] rst_tab [0:7] = '{32'h0, 32'h1, 32'h2, 32'h0, 32'h32, 32'h0, 32'h64, 32'h0};
	int cn [0:2] = '{20, 10, 100};
	int cd [0:2] = '{3, 1, 1};
	int ln [0:1] = '{36000, 3000};
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	int mp, mh, c0, p, s, v;

	sptg_top #(.QUANT_CYCLES(Q)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
		.avs_address_in(adr), .avs_read_in(rd_req), .avs_write_in(wr_req),
		.avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req),
		.encoder_present_in(enc_present), .encoder_angle_in(angle),
		.encoder_emulation_in(emul), .process_value_in(pv_tab[vsel]),
		.value_select_out(vsel), .pulse_train_out(pulse), .open_collector_out_1(oc1),
		.open_collector_out_2(oc2), .open_collector_out_3(oc3), .open_collector_out_4(oc4));

	sptg_pulse_rx rx (.clk_in(clk_in), .rstn_in(rstn_in), .line_in(oc1),
		.rise_count_out(rx_rises), .period_out(rx_period), .high_out(rx_high));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, shaft angles at two rates, cycle ceiling
	always #4 clk_in = ~clk_in;

	always @(posedge clk_in)
	begin
		angle <= angle + 16'h0010;
		emul <= emul + 16'h0020;
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	// Outputs follow the pulse through the route mask; edges skipped for the lag
	always @(negedge clk_in)
	begin
		if (rstn_in && pulse === prev_pulse)
			check({28'h0, oc4, oc3, oc2, oc1}, {28'h0, {4{pulse}} & route_m}, 0);
		prev_pulse <= pulse;
	end

	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
		int d;
		begin
			n_checks++;
			d = int'(seen) - int'(exp);
			if (!((seen === exp) || (!$isunknown(seen) && d <= tol && d >= -tol)))
			begin
				n_mismatch++;
				$display("CHECK FAILED at %0t: seen %0d expected %0d", $time, seen, exp);
			end
		end
	endtask : check

	// Request held until waitrequest is sampled low, one idle edge after
	task bus_write(input logic [5:0] a, input logic [31:0] d);
		begin
			adr <= a;
			wdat <= d;
			wr_req <= 1'b1;
			@(posedge clk_in);
			while (wait_req !== 1'b0)
				@(posedge clk_in);
			wr_req <= 1'b0;
			@(posedge clk_in);
			if (a == `SPTG_OFS_ROUTE)
				route_m = d[3:0];
		end
	endtask : bus_write

	task bus_read(input logic [5:0] a, output logic [31:0] d);
		begin
			adr <= a;
			rd_req <= 1'b1;
			@(posedge clk_in);
			while (wait_req !== 1'b0)
				@(posedge clk_in);
			d = rdat;
			rd_req <= 1'b0;
			@(posedge clk_in);
		end
	endtask : bus_read

	// Waits four periods so the new setting is latched, compares in quanta
	task expect_train(input int p_us, input int len_us);
		begin
			c0 = int'(rx_rises);
			while (int'(rx_rises) < c0 + 4)
				@(posedge clk_in);
			mp = (int'(rx_period) + Q / 2) / Q;
			mh = (int'(rx_high) + Q / 2) / Q;
			check(32'(mp), 32'((p_us + 1499) / 1500), 1);
			check(32'(mh), 32'((len_us + 1499) / 1500), 1);
		end
	endtask : expect_train

	task print_verdict();
		begin
			if (n_mismatch == 0 && n_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hA9451999));
		for (int i = 0; i < 64; i++)
			pv_tab[i] = 16'h0000;
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		// Reset values, then an unmapped write must not disturb the map
		for (int i = 0; i < 8; i++)
		begin
			bus_read(6'(i * 4), rd);
			check(rd, rst_tab[i], 0);
		end
		check(32'(rx_rises), 32'h0, 0);
		bus_write(6'h28, 32'h0000_0003);
		bus_read(6'h28, rd);
		check(rd, 32'h0, 0);
		bus_read(`SPTG_OFS_NUM, rd);
		check(rd, 32'h1, 0);
		bus_write(`SPTG_OFS_ROUTE, 32'h0000_0005);
		// Constant mode: ratio in hertz, fifth of period, 3 ms floor
		for (int i = 0; i < 3; i++)
		begin
			bus_write(`SPTG_OFS_NUM, 32'(cn[i]));
			bus_write(`SPTG_OFS_DEN, 32'(cd[i]));
			bus_write(`SPTG_OFS_CTRL, 32'h0000_0002);
			p = 1000000 * cd[i] / cn[i];
			expect_train(p, (p / 5 > 3000) ? p / 5 : 3000);
			bus_read(`SPTG_OFS_PERIOD, rd);
			check(rd, 32'(p), p / 100);
		end
		// Error carry at 100 Hz: 6.67 quanta on average, 63 periods in 420
		bus_write(`SPTG_OFS_CTRL, 32'h0000_0102);
		expect_train(10000, 3000);
		c0 = int'(rx_rises);
		repeat (420 * Q) @(posedge clk_in);
		check(32'(int'(rx_rises) - c0), 32'd63, 1);
		// Off and out-of-range selectors stop the train
		for (int i = 0; i < 2; i++)
		begin
			bus_write(`SPTG_OFS_CTRL, i == 0 ? 32'h0000_0039 : 32'h0000_0000);
			repeat (5 * Q) @(posedge clk_in);
			c0 = int'(rx_rises);
			repeat (20 * Q) @(posedge clk_in);
			check(32'(int'(rx_rises) - c0), 32'h0, 0);
			check({31'h0, pulse}, 32'h0, 0);
		end
		// Status reads idle and low once the selector is zero
		bus_read(`SPTG_OFS_STATUS, rd);
		check(rd, 32'h0, 0);
		// Value mode with default ratio: 25 Hz, half period; then clamps
		pv_tab[3] <= 16'h0032;
		bus_write(`SPTG_OFS_DEN, 32'h0000_0002);
		bus_write(`SPTG_OFS_NUM, 32'h0000_0001);
		bus_write(`SPTG_OFS_CTRL, 32'h0000_0003);
		expect_train(40000, 20000);
		check({26'h0, vsel}, 32'h3, 0);
		for (int i = 0; i < 2; i++)
		begin
			bus_write(`SPTG_OFS_NUM, i == 0 ? 32'h0000_0013 : 32'h0000_0001);
			bus_write(`SPTG_OFS_DEN, i == 0 ? 32'h0000_0014 : 32'h0000_0064);
			expect_train(40000, ln[i]);
		end
		// Random selectors over a bipolar input range, 10..60 Hz
		bus_write(`SPTG_OFS_FMIN, 32'h0000_000A);
		bus_write(`SPTG_OFS_FMAX, 32'h0000_003C);
		bus_write(`SPTG_OFS_INMIN, 32'h0000_FF38);
		bus_write(`SPTG_OFS_INMAX, 32'h0000_00C8);
		bus_write(`SPTG_OFS_NUM, 32'h0000_0001);
		bus_write(`SPTG_OFS_DEN, 32'h0000_0002);
		for (int i = 0; i < 3; i++)
		begin
			s = int'($urandom_range(56, 3));
			v = int'($urandom_range(400, 0)) - 200;
			pv_tab[s] <= 16'(v);
			bus_write(`SPTG_OFS_CTRL, 32'(s));
			p = 1000000000 / (10000 + (v + 200) * 125);
			expect_train(p, p / 2);
			check({26'h0, vsel}, 32'(s), 0);
		end
		// Revolution mode: four per turn from encoder, then from emulation
		bus_write(`SPTG_OFS_NUM, 32'h0000_0004);
		bus_write(`SPTG_OFS_DEN, 32'h0000_0001);
		bus_write(`SPTG_OFS_CTRL, 32'h0000_0001);
		expect_train(76800, 15360);
		enc_present <= 1'b0;
		expect_train(38400, 7680);
		// Clock enable low freezes the train; two edges let the receiver settle
		ce <= 1'b0;
		repeat (2) @(posedge clk_in);
		c0 = int'(rx_rises);
		mp = int'(pulse);
		repeat (10 * Q) @(posedge clk_in);
		check(32'(int'(rx_rises) - c0), 32'h0, 0);
		check({31'h0, pulse}, 32'(mp), 0);
		ce <= 1'b1;
		print_verdict();
	end
endmodule : sptg_top_bench
